/* src/burst_fifo.sv */
// first-in first-out buffer for captured write beats
// assumes: depth is a power of two; same clock on both sides
`timescale 1ns/1ps
module burst_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int unsigned      PTR_W      = $clog2(DEPTH);
  localparam logic [PTR_W:0]   FULL_COUNT = (PTR_W+1)'(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   count;
  } fifo_state_t;

  fifo_state_t      s;
  fifo_state_t      next_s;
  logic [WIDTH-1:0] store [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (s.count != FULL_COUNT);
  assign out_valid = (s.count != '0);
  assign out_data  = store[s.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wr_ptr = s.wr_ptr + PTR_W'(1);
    end
    if (pop) begin
      next_s.rd_ptr = s.rd_ptr + PTR_W'(1);
    end
    if (push && !pop) begin
      next_s.count = s.count + (PTR_W+1)'(1);
    end else if (pop && !push) begin
      next_s.count = s.count - (PTR_W+1)'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      store[s.wr_ptr] <= in_data;
    end
  end

endmodule

/* src/ddr_burst_engine.sv */
// ddr3 device-side burst engine: command decode, read and write bursts
// assumes: link clock, strobe, data and command pins are asynchronous to
// clk_sys and run at least eight times slower than it
`timescale 1ns/1ps

// Operation
// [R1] the controller spaces a precharge after a read to the same bank by additive latency plus read-to-precharge delay.
// [R2] the controller takes that read-to-precharge delay as at least four link cycles and at least 7.5 ns.
// [R3] the controller also keeps the activate-to-precharge minimum when precharging after a read.
// [R4] the controller re-activates a bank only after both precharge time and row cycle time have elapsed.
// [R5] address bit twelve of each read or write picks a four-beat chop when low and eight beats when high.
// [R6] the per-command choice of burst length applies only while the mode burst field holds the on-the-fly code.
// [R7] broken write data setup or hold corrupts only the addressed location and the device keeps working.
// [R8] broken write strobe timing corrupts only the addressed location and never hangs the device.
// [R9] after any other timing violation the controller runs a full reset and initialisation.
// [R10] the controller meets strobe timing on every edge of a write burst, shared edges included.
module ddr_burst_engine
  import ddr_burst_pkg::*;
#(
  parameter int unsigned BUF_DEPTH = FIFO_DEPTH
) (
  input  wire logic            clk_sys,
  input  wire logic            reset,
  input  wire logic            ck_link,
  input  wire cmd_pins_t       cmd_pins,
  input  wire logic [DQ_W-1:0] dq_in,
  input  wire logic            dqs_in,
  output logic      [DQ_W-1:0] dq_out,
  output logic                 dq_oe,
  output logic                 dqs_out,
  output logic                 dqs_oe,
  output logic                 write_overrun
);

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  engine_state_t   s;
  engine_state_t   next_s;
  logic [DQ_W-1:0] mem [2**IDX_W];
  wr_beat_t        push_beat;
  logic            push_valid;
  logic            push_ready;
  wr_beat_t        drain_beat;
  logic            drain_valid;
  logic            drain_ready;
  logic            ck_rise;
  logic            ck_edge;
  logic            dqs_edge;
  logic            busy;
  logic [3:0]      cmd_code;
  logic [IDX_W-1:0] rd_idx;
  logic [IDX_W-1:0] wr_idx;

  function automatic logic [3:0] burst_beats(input logic [1:0] mode, input logic sel);
    logic [3:0] beats;
    beats = BEATS_FULL;
    if (mode == BL_FIXED4) begin
      beats = BEATS_CHOP;
    end else if (mode == BL_OTF) begin
      beats = sel ? BEATS_FULL : BEATS_CHOP;
    end
    return beats;
  endfunction

  assign ck_rise  = s.ck2 && !s.ck3;
  assign ck_edge  = s.ck2 ^ s.ck3;
  assign dqs_edge = s.dqs2 ^ s.dqs3;
  assign busy     = (s.rd_ph != PH_IDLE) || (s.wr_ph != PH_IDLE);
  assign cmd_code = {s.cmd2.cs_n, s.cmd2.ras_n, s.cmd2.cas_n, s.cmd2.we_n};
  assign rd_idx   = {s.rd_base[IDX_W-1:3], s.rd_base[2:0] + s.rd_off};
  assign wr_idx   = {s.wr_base[IDX_W-1:3], s.wr_base[2:0] + s.wr_off};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s     = s;
    push_valid = 1'b0;
    push_beat  = '{idx: wr_idx, data: s.dq2};
    next_s.ck1  = ck_link;
    next_s.ck2  = s.ck1;
    next_s.ck3  = s.ck2;
    next_s.dqs1 = dqs_in;
    next_s.dqs2 = s.dqs1;
    next_s.dqs3 = s.dqs2;
    next_s.cmd1 = cmd_pins;
    next_s.cmd2 = s.cmd1;
    next_s.dq1  = dq_in;
    next_s.dq2  = s.dq1;

    // command decode; commands during a running burst are ignored
    if (ck_rise && !busy) begin
      if (cmd_code == CMD_MODE && s.cmd2.bank == '0) begin
        next_s.mr_bl = s.cmd2.addr[MR_BL_LSB +: 2];
      end else if (cmd_code == CMD_READ) begin
        next_s.rd_ph   = PH_WAIT;
        next_s.rd_cnt  = READ_LATENCY;
        next_s.rd_left = burst_beats(s.mr_bl, s.cmd2.addr[BURST_SEL_BIT]);  // see [R5] see [R6]
        next_s.rd_base = {s.cmd2.bank, s.cmd2.addr[COL_W-1:0]};
        next_s.rd_off  = '0;
      end else if (cmd_code == CMD_WRITE) begin
        next_s.wr_ph    = PH_WAIT;
        next_s.wr_cnt   = WRITE_LATENCY;
        next_s.wr_left  = burst_beats(s.mr_bl, s.cmd2.addr[BURST_SEL_BIT]);  // see [R5] see [R6]
        next_s.wr_base  = {s.cmd2.bank, s.cmd2.addr[COL_W-1:0]};
        next_s.wr_off   = '0;
        next_s.wr_timer = '0;
      end
    end

    // read burst: preamble one link cycle early, then a beat per edge
    unique case (s.rd_ph)
      PH_IDLE: begin
      end
      PH_WAIT: begin
        if (ck_rise) begin
          next_s.rd_cnt = s.rd_cnt - 4'h1;
          if (s.rd_cnt == 4'h2) begin
            next_s.dqs_oe  = 1'b1;
            next_s.dqs_out = 1'b0;
          end
          if (s.rd_cnt == 4'h1) begin
            next_s.rd_ph   = PH_BURST;
            next_s.dq_out  = mem[rd_idx];
            next_s.dq_oe   = 1'b1;
            next_s.dqs_oe  = 1'b1;
            next_s.dqs_out = 1'b1;
            next_s.rd_off  = s.rd_off + 3'h1;
            next_s.rd_left = s.rd_left - 4'h1;
          end
        end
      end
      PH_BURST: begin
        if (ck_edge) begin
          if (s.rd_left == 4'h0) begin
            next_s.rd_ph   = PH_IDLE;
            next_s.dq_oe   = 1'b0;
            next_s.dqs_oe  = 1'b0;
            next_s.dqs_out = 1'b0;
          end else begin
            next_s.dq_out  = mem[rd_idx];
            next_s.dqs_out = !s.dqs_out;
            next_s.rd_off  = s.rd_off + 3'h1;
            next_s.rd_left = s.rd_left - 4'h1;
          end
        end
      end
    endcase

    // write burst: beats on strobe edges, watchdog closes it regardless
    if (s.wr_ph != PH_IDLE && ck_rise) begin
      next_s.wr_timer = s.wr_timer + 5'h1;
    end
    unique case (s.wr_ph)
      PH_IDLE: begin
      end
      PH_WAIT: begin
        if (ck_rise) begin
          next_s.wr_cnt = s.wr_cnt - 4'h1;
          if (s.wr_cnt == 4'h1) begin
            next_s.wr_ph = PH_BURST;
          end
        end
      end
      PH_BURST: begin
        if (dqs_edge) begin
          push_valid     = 1'b1;                 // see [R7]
          next_s.wr_off  = s.wr_off + 3'h1;
          next_s.wr_left = s.wr_left - 4'h1;
          if (s.wr_left == 4'h1) begin
            next_s.wr_ph = PH_IDLE;
          end
          if (!push_ready) begin
            next_s.overrun = 1'b1;
          end
        end
      end
    endcase
    if (s.wr_ph != PH_IDLE && s.wr_timer >= WR_TIMEOUT) begin
      next_s.wr_ph = PH_IDLE;                    // see [R8]
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s       <= '0;
      s.mr_bl <= MR_BL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // write beat buffer and array update
  // ----------------------------------------------------------------
  assign drain_ready = (s.rd_ph != PH_BURST);

  burst_fifo #(
    .WIDTH ($bits(wr_beat_t)),
    .DEPTH (BUF_DEPTH)
  ) u_beat_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (push_valid),
    .in_data   (push_beat),
    .in_ready  (push_ready),
    .out_valid (drain_valid),
    .out_data  (drain_beat),
    .out_ready (drain_ready)
  );

  always_ff @(posedge clk_sys) begin
    if (drain_valid && drain_ready) begin
      mem[drain_beat.idx] <= drain_beat.data;    // see [R7]
    end
  end

  assign dq_out        = s.dq_out;
  assign dq_oe         = s.dq_oe;
  assign dqs_out       = s.dqs_out;
  assign dqs_oe        = s.dqs_oe;
  assign write_overrun = s.overrun;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  logic rd_take;
  logic wr_take;
  assign rd_take = ck_rise && !busy && cmd_code == CMD_READ;
  assign wr_take = ck_rise && !busy && cmd_code == CMD_WRITE;

  a_otf_chop_len: assert property (  // see [R5]
    rd_take && s.mr_bl == BL_OTF && !s.cmd2.addr[BURST_SEL_BIT] |=> s.rd_left == BEATS_CHOP)
    else $error("otf chop read not four beats");
  a_otf_full_len: assert property (  // see [R5]
    wr_take && s.mr_bl == BL_OTF && s.cmd2.addr[BURST_SEL_BIT] |=> s.wr_left == BEATS_FULL)
    else $error("otf full write not eight beats");
  a_fixed_mode_len: assert property (  // see [R6]
    rd_take && s.mr_bl == BL_FIXED8 |=> s.rd_left == BEATS_FULL)
    else $error("fixed mode ignored by read");
  a_write_confined: assert property (  // see [R7]
    push_valid |-> s.wr_left != 4'h0 && push_beat.idx[IDX_W-1:3] == s.wr_base[IDX_W-1:3])
    else $error("write beat left its burst");
  a_write_no_hang: assert property (  // see [R8]
    s.wr_ph != PH_IDLE |-> s.wr_timer <= WR_TIMEOUT)
    else $error("write burst outlived watchdog");
  a_read_release: assert property (s.rd_ph == PH_BURST ##1 s.rd_ph == PH_IDLE
    |-> !s.dq_oe && !s.dqs_oe) else $error("pins still driven after read");
  a_overrun_sticky: assert property ($rose(s.overrun)
    |=> s.overrun [*3]) else $error("overrun flag dropped");

  c_chop_read: cover property (rd_take && s.mr_bl == BL_OTF && !s.cmd2.addr[BURST_SEL_BIT]);
  c_full_write: cover property (s.wr_ph == PH_BURST && s.wr_left == 4'h1 && dqs_edge);
  c_watchdog: cover property (s.wr_ph != PH_IDLE && s.wr_timer >= WR_TIMEOUT);
  c_mode_set: cover property (ck_rise && !busy && cmd_code == CMD_MODE);

endmodule

/* src/ddr_burst_pkg.sv */
// constants and types of the ddr3 burst read/write engine
// assumes: one system clock domain; pins arrive unsynchronised
package ddr_burst_pkg;

  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int unsigned DQ_W          = 8;
  localparam int unsigned BANK_W        = 3;
  localparam int unsigned ADDR_W        = 14;
  localparam int unsigned COL_W         = 5;
  localparam int unsigned IDX_W         = BANK_W + COL_W;
  localparam int unsigned BURST_SEL_BIT = 12;
  localparam int unsigned MR_BL_LSB     = 0;
  localparam int unsigned FIFO_DEPTH    = 32;

  // ----------------------------------------------------------------
  // mode register zero burst length codes
  // ----------------------------------------------------------------
  localparam logic [1:0] BL_FIXED8  = 2'h0;
  localparam logic [1:0] BL_OTF     = 2'h1;
  localparam logic [1:0] BL_FIXED4  = 2'h2;
  localparam logic [1:0] MR_BL_RESET = BL_FIXED8;

  // ----------------------------------------------------------------
  // counts, in link clock cycles or beats
  // ----------------------------------------------------------------
  localparam logic [3:0] BEATS_CHOP    = 4'h4;
  localparam logic [3:0] BEATS_FULL    = 4'h8;
  localparam logic [3:0] READ_LATENCY  = 4'h6;
  localparam logic [3:0] WRITE_LATENCY = 4'h5;
  localparam logic [4:0] WR_TIMEOUT    = 5'h0C;

  // ----------------------------------------------------------------
  // command codes {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_MODE  = 4'h0;
  localparam logic [3:0] CMD_READ  = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;

  typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_BURST} phase_t;

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_t;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [DQ_W-1:0]  data;
  } wr_beat_t;

  typedef struct packed {
    logic             ck1, ck2, ck3;
    logic             dqs1, dqs2, dqs3;
    cmd_pins_t        cmd1, cmd2;
    logic [DQ_W-1:0]  dq1, dq2;
    logic [1:0]       mr_bl;
    phase_t           rd_ph;
    logic [3:0]       rd_cnt;
    logic [3:0]       rd_left;
    logic [IDX_W-1:0] rd_base;
    logic [2:0]       rd_off;
    phase_t           wr_ph;
    logic [3:0]       wr_cnt;
    logic [3:0]       wr_left;
    logic [IDX_W-1:0] wr_base;
    logic [2:0]       wr_off;
    logic [4:0]       wr_timer;
    logic [DQ_W-1:0]  dq_out;
    logic             dq_oe;
    logic             dqs_out;
    logic             dqs_oe;
    logic             overrun;
  } engine_state_t;

endpackage

/* testbench/ddr_burst_engine_tb.sv */
// testbench of the burst engine; its write buffer is reached through the top
// assumes: controller model drives the link pins; reads checked from a queue
`timescale 1ns/1ps
module ddr_burst_engine_tb
  import ddr_burst_pkg::*;
;
  logic            clk_sys;
  logic            reset;
  logic            ck_link;
  cmd_pins_t       cmd_pins;
  logic [DQ_W-1:0] dq_in;
  logic            dqs_in;
  logic [DQ_W-1:0] dq_out;
  logic            dq_oe;
  logic            dqs_out;
  logic            dqs_oe;
  logic            write_overrun;
  logic [DQ_W-1:0] exp_q [$];
  logic [DQ_W-1:0] mem [256];
  logic [1:0]      modes [3] = '{BL_FIXED8, BL_OTF, BL_FIXED4};
  logic            prev_oe;
  logic            prev_dqs;
  int              bad_count;
  int              n_tests;
  int              cycles;
  int              beats_seen;

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  ddr_burst_engine #(.BUF_DEPTH(FIFO_DEPTH)) dut (
    .clk_sys(clk_sys), .reset(reset), .ck_link(ck_link), .cmd_pins(cmd_pins), .dq_in(dq_in),
    .dqs_in(dqs_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
    .write_overrun(write_overrun));
  ddr_ctrl_model ctrl (.ck_link(ck_link), .cmd_pins(cmd_pins), .dq_in(dq_in), .dqs_in(dqs_in));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic set_mode(input logic [BANK_W-1:0] b, input logic [1:0] code);
    ctrl.issue(CMD_MODE, b, {12'h000, code});
    repeat (2) @(posedge ck_link);
  endtask

  task automatic do_write(input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a, input int edges);
    logic [DQ_W-1:0] d [8];
    for (int k = 0; k < 8; k++) d[k] = 8'($urandom);
    for (int k = 0; k < edges; k++) mem[{b, a[4:3], 3'(a[2:0] + 3'(k))}] = d[k];
    ctrl.issue(CMD_WRITE, b, a);
    ctrl.write_beats(d, edges);
    repeat (14) @(posedge ck_link);
  endtask

  // expected beats noted in the queue; watcher pops them
  task automatic do_read(input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a, input int n);
    for (int k = 0; k < n; k++) exp_q.push_back(mem[{b, a[4:3], 3'(a[2:0] + 3'(k))}]);
    ctrl.issue(CMD_READ, b, a);
    repeat (12) @(posedge ck_link);
    check("beats missing", 8'h00, 8'(exp_q.size()));
    exp_q.delete();
  endtask

  // ------------------------------------------------------------
  // read watcher and timeout
  // ------------------------------------------------------------
  always @(negedge clk_sys) begin
    if (dq_oe === 1'b1 && (prev_oe !== 1'b1 || dqs_out !== prev_dqs)) begin
      beats_seen++;
      if (exp_q.size() > 0) begin
        check("read beat", exp_q.pop_front(), dq_out);
      end else begin
        check("extra beat", 8'h00, 8'h01);
      end
    end
    prev_oe  <= dq_oe;
    prev_dqs <= dqs_out;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      $display("FAIL timeout expected done seen hang");
      report_and_stop();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int n;
    int seen0;
    logic [BANK_W-1:0] b;
    logic [ADDR_W-1:0] a;
    logic [COL_W-1:0]  col;
    reset = 1'b1;
    void'($urandom(32'h3C33AFBC));
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    check("idle outputs", 8'h00, {4'h0, dq_oe, dqs_oe, dqs_out, |dq_out});
    // default fixed eight, bit twelve low still gives eight
    do_write(3'h0, 14'h0000, 8);
    do_read(3'h0, 14'h0000, 8);
    // every mode, both burst select values at one random place; long write
    // first, so a later long read never meets an unwritten location
    for (int m = 0; m < 3; m++) begin
      set_mode(3'h0, modes[m]);
      b   = 3'($urandom);
      col = 5'($urandom);
      for (int s = 1; s >= 0; s--) begin
        a = {1'b0, 1'(s), 7'h00, col};
        n = (modes[m] == BL_FIXED8 || (modes[m] == BL_OTF && s == 1)) ? 8 : 4;
        do_write(b, a, n);
        do_read(b, a ^ 14'h1000, (modes[m] == BL_OTF) ? 12 - n : n);
      end
    end
    // mode set to a nonzero bank is ignored: stays fixed four
    set_mode(3'h1, BL_OTF);
    do_read(3'h0, 14'h1000, 4);
    // two strobe edges only: watchdog closes, rest keeps old data
    do_write(3'h0, 14'h0002, 2);
    do_read(3'h0, 14'h0002, 4);
    // full reset after the broken burst: idle pins, mode back to fixed eight
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    check("reset outputs", 8'h00, {4'h0, dq_oe, dqs_oe, dqs_out, |dq_out});
    repeat (2) @(posedge ck_link);
    do_read(3'h0, 14'h0000, 8);
    set_mode(3'h0, BL_OTF);
    do_write(3'h6, 14'h101D, 8);
    do_read(3'h6, 14'h101D, 8);
    check("overrun flag", 8'h00, {7'h00, write_overrun});
    // buffer: four long writes with idle link cycles between them, then all read back in order
    for (int k = 0; k < 4; k++) begin
      do_write(3'h5, 14'h1000 + 14'(8 * k), 8);
    end
    check("buffer depth", 8'h00, {7'h00, write_overrun});
    seen0 = beats_seen;
    for (int k = 0; k < 4; k++) begin
      do_read(3'h5, 14'h1000 + 14'(8 * k), 8);
    end
    check("buffer order", 8'h20, 8'(beats_seen - seen0));
    report_and_stop();
  end
endmodule

/* testbench/ddr_ctrl_model.sv */
// controller model: free-running link clock, commands, write strobe and data
// assumes: the device samples every pin with its own faster clock
`timescale 1ns/1ps
module ddr_ctrl_model
  import ddr_burst_pkg::*;
(
  output logic            ck_link,
  output cmd_pins_t       cmd_pins,
  output logic [DQ_W-1:0] dq_in,
  output logic            dqs_in
);
  // ------------------------------------------------------------
  // link clock, phase unrelated to clk_sys
  // ------------------------------------------------------------
  initial begin
    ck_link  = 1'b0;
    cmd_pins = '1;
    dq_in    = '0;
    dqs_in   = 1'b0;
    #37;
    forever #100 ck_link = ~ck_link;
  end

  // ------------------------------------------------------------
  // command for one link cycle, then deselect with inverted address
  // ------------------------------------------------------------
  // no precharge or activate is ever sent, so bank spacing holds
  task automatic issue(input logic [3:0] code, input logic [BANK_W-1:0] bank, input logic [ADDR_W-1:0] addr);
    @(negedge ck_link);
    cmd_pins <= {code, bank, addr};
    @(negedge ck_link);
    cmd_pins <= {4'hF, ~bank, ~addr};
  endtask

  // ------------------------------------------------------------
  // write beats: data on each link edge from rise five, strobe a quarter
  // link cycle later, so the burst is already open when the strobe lands
  // ------------------------------------------------------------
  task automatic write_beats(input logic [DQ_W-1:0] d [8], input int edges);
    repeat (4) @(negedge ck_link);
    for (int k = 0; k < edges; k++) begin
      @(ck_link);
      dq_in <= d[k];
      #50;
      dqs_in <= ~dqs_in;
    end
    @(ck_link);
    dq_in <= ~dq_in;
  endtask
endmodule
